// >>> rtl/rwt_pkg.sv
// readout window and timing register bank: shared constants and types
// assumes byte-wide registers reached through the sensor's serial control port
package rwt_pkg;

    typedef logic [7:0] byte_t;

    // number of registers held in this bank
    localparam int NUM_REGS = 12;

    // register indices inside the bank
    localparam int IDX_HORIZONTAL_SCAN_CONTROL = 0;
    localparam int IDX_INTEGRATION_CONFIG = 1;
    localparam int IDX_WINDOW_FIRST_ROW_HIGH = 2;
    localparam int IDX_WINDOW_LAST_ROW_HIGH = 3;
    localparam int IDX_WINDOW_ROW_LOW_BITS = 4;
    localparam int IDX_WINDOW_FIRST_COL_HIGH = 5;
    localparam int IDX_WINDOW_LAST_COL_HIGH = 6;
    localparam int IDX_WINDOW_COL_LOW_BITS = 7;
    localparam int IDX_FRAME_GAP_HIGH = 8;
    localparam int IDX_FRAME_GAP_LOW = 9;
    localparam int IDX_LINE_GAP_HIGH = 10;
    localparam int IDX_LINE_GAP_LOW = 11;

    // register addresses, in index order
    localparam byte_t REG_OFFSET [0:NUM_REGS-1] = '{
        8'h13, 8'h15, 8'h19, 8'h1A, 8'h1B, 8'h1C,
        8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h23
    };

    // values after reset, in index order
    localparam byte_t REG_RESET [0:NUM_REGS-1] = '{
        8'h04, 8'h08, 8'h00, 8'h80, 8'h23, 8'h00,
        8'hA0, 8'h23, 8'h00, 8'h08, 8'h00, 8'h08
    };

    // implemented bits; reserved bits are not stored and read as zero
    localparam byte_t REG_MASK [0:NUM_REGS-1] = '{
        8'h07, 8'h08, 8'hFF, 8'hFF, 8'h3F, 8'hFF,
        8'hFF, 8'h3F, 8'hFF, 8'h7F, 8'hFF, 8'h1F
    };

    // field positions
    localparam int POS_COLUMN_ORDER = 2;
    localparam int POS_COLUMN_SUBSAMPLE = 1;
    localparam int POS_COLUMN_AVERAGE = 0;
    localparam int POS_PARTIAL_FRAME = 3;
    localparam int POS_FIRST_BIT2 = 5;
    localparam int POS_LAST_BIT2 = 2;

    // field widths
    localparam int WINDOW_W = 11;
    localparam int FRAME_GAP_W = 15;
    localparam int FRAME_GAP_LOW_W = 7;
    localparam int LINE_GAP_W = 13;
    localparam int LINE_GAP_LOW_W = 5;

    // hard-wired low bits of the window edges
    localparam logic [1:0] FIRST_LOW2 = 2'h0;
    localparam logic [1:0] LAST_LOW2 = 2'h3;

    // read data when nothing is addressed
    localparam byte_t READ_IDLE = 8'h00;

endpackage

// >>> rtl/shadow_wr_if.sv
// write path from the register decoder to the shadow bytes
// assumes one clock; select is one-hot and lasts one cycle per write
`timescale 1ns/1ps
`default_nettype none
interface shadow_wr_if;
    import rwt_pkg::*;
    logic [NUM_REGS-1:0] sel;
    byte_t wdata;
    modport master (output sel, output wdata);
    modport target (input sel, input wdata);
endinterface
`default_nettype wire

// >>> rtl/shadow_byte.sv
// one shadow byte of the bank: stores what the host writes
// assumes the decoder raises at most one select per cycle
`timescale 1ns/1ps
`default_nettype none
module shadow_byte
    import rwt_pkg::*;
#(
    parameter int INDEX = 0
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    shadow_wr_if.target wr,
    output byte_t o_value
);
    initial begin
        if (INDEX < 0 || INDEX >= NUM_REGS) begin
            $error("shadow_byte index out of range");
        end
    end

    byte_t value_r;
    byte_t value_nxt;

    // reserved bits are dropped on the way in
    assign value_nxt = wr.sel[INDEX] ? (wr.wdata & REG_MASK[INDEX]) : value_r;

    // shadow copy, synchronous reset
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            value_r <= REG_RESET[INDEX];
        end else begin
            value_r <= value_nxt;
        end
    end

    assign o_value = value_r;
endmodule
`default_nettype wire

// >>> rtl/window_compose.sv
// assembles window edges and delay counts out of the shadow bytes
// assumes the bytes are already masked to their implemented bits
`timescale 1ns/1ps
`default_nettype none
module window_compose
    import rwt_pkg::*;
(
    input byte_t i_shadow [0:NUM_REGS-1],
    output logic o_column_order_select,
    output logic o_column_subsample_enable,
    output logic o_column_average_enable,
    output logic o_partial_frame_enable,
    output logic [WINDOW_W-1:0] o_window_first_row,
    output logic [WINDOW_W-1:0] o_window_last_row,
    output logic [WINDOW_W-1:0] o_window_first_col,
    output logic [WINDOW_W-1:0] o_window_last_col,
    output logic [FRAME_GAP_W-1:0] o_frame_gap,
    output logic [LINE_GAP_W-1:0] o_line_gap
);
    byte_t horizontal_scan_control;
    byte_t row_low;
    byte_t col_low;

    assign horizontal_scan_control = i_shadow[IDX_HORIZONTAL_SCAN_CONTROL];
    assign row_low = i_shadow[IDX_WINDOW_ROW_LOW_BITS];
    assign col_low = i_shadow[IDX_WINDOW_COL_LOW_BITS];

    assign o_column_order_select = horizontal_scan_control[POS_COLUMN_ORDER];
    assign o_column_average_enable = horizontal_scan_control[POS_COLUMN_AVERAGE];
    assign o_column_subsample_enable = horizontal_scan_control[POS_COLUMN_SUBSAMPLE] | horizontal_scan_control[POS_COLUMN_AVERAGE];
    assign o_partial_frame_enable = i_shadow[IDX_INTEGRATION_CONFIG][POS_PARTIAL_FRAME];

    assign o_window_first_row = {i_shadow[IDX_WINDOW_FIRST_ROW_HIGH], row_low[POS_FIRST_BIT2], FIRST_LOW2};
    assign o_window_last_row = {i_shadow[IDX_WINDOW_LAST_ROW_HIGH], row_low[POS_LAST_BIT2], LAST_LOW2};
    assign o_window_first_col = {i_shadow[IDX_WINDOW_FIRST_COL_HIGH], col_low[POS_FIRST_BIT2], FIRST_LOW2};
    assign o_window_last_col = {i_shadow[IDX_WINDOW_LAST_COL_HIGH], col_low[POS_LAST_BIT2], LAST_LOW2};

    assign o_frame_gap = {i_shadow[IDX_FRAME_GAP_HIGH], i_shadow[IDX_FRAME_GAP_LOW][FRAME_GAP_LOW_W-1:0]};
    assign o_line_gap = {i_shadow[IDX_LINE_GAP_HIGH], i_shadow[IDX_LINE_GAP_LOW][LINE_GAP_LOW_W-1:0]};
endmodule
`default_nettype wire

// >>> rtl/readout_window_timing_regs.sv
// readout window and timing register bank of the sensor's timing logic
// assumes the serial control slave hands over byte accesses on i_mclk,
// and the timing logic pulses i_frame_boundary once between frames
//
// What this block does
// - bit 2 selects column order, default left-right
// - bit 1 enables column subsampling, default off
// - bit 0 enables column averaging, default off
// - averaging forces subsampling on
// - bit 3 enables partial frame integration
// - first row: high byte plus bit 5
// - first row low two bits fixed zero
// - last row: high byte plus bit 2
// - last row low two bits fixed ones
// - first column: high byte plus bit 5
// - first column low two bits zero
// - last column: high byte plus bit 2
// - last column low two bits ones
// - frame gap fifteen bits, high and low
// - line gap bits 12:5 from high register
// - line gap bits 4:0 from low register
`timescale 1ns/1ps
`default_nettype none
module readout_window_timing_regs
    import rwt_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_frame_boundary,
    output logic [7:0] o_rdata,
    output logic o_rd_valid,
    output logic o_addr_hit,
    output logic o_update_pending,
    output logic o_applied,
    output logic o_column_order_select,
    output logic o_column_subsample_enable,
    output logic o_column_average_enable,
    output logic o_partial_frame_enable,
    output logic [WINDOW_W-1:0] o_window_first_row,
    output logic [WINDOW_W-1:0] o_window_last_row,
    output logic [WINDOW_W-1:0] o_window_first_col,
    output logic [WINDOW_W-1:0] o_window_last_col,
    output logic [FRAME_GAP_W-1:0] o_frame_gap,
    output logic [LINE_GAP_W-1:0] o_line_gap
);
    // the address must reach the highest register offset
    initial begin
        if (ADDR_W < 6) begin
            $error("ADDR_W too narrow for the register map");
        end
    end

    // returns one-hot select of the addressed register, zero when unmapped
    function automatic logic [NUM_REGS-1:0] decode(input logic [ADDR_W-1:0] addr);
        logic [NUM_REGS-1:0] hit;
        hit = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (addr == ADDR_W'(REG_OFFSET[i])) begin
                hit[i] = 1'b1;
            end
        end
        return hit;
    endfunction

    shadow_wr_if wr_bus ();
    byte_t shadow [0:NUM_REGS-1];
    logic [NUM_REGS-1:0] addr_sel;
    logic any_hit;
    logic any_write;
    byte_t read_mux;

    // address decode shared by read and write
    assign addr_sel = decode(i_addr);
    assign any_hit = |addr_sel;
    assign any_write = i_wr_en & any_hit;

    // write path; writes to unmapped addresses are dropped
    assign wr_bus.sel = i_wr_en ? addr_sel : '0;
    assign wr_bus.wdata = i_wdata;

    // low bits stored, window ignores them
    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_shadow
            shadow_byte #(
                .INDEX(g)
            ) u_shadow (
                .i_mclk(i_mclk),
                .i_resetn(i_resetn),
                .wr(wr_bus.target),
                .o_value(shadow[g])
            );
        end
    endgenerate

    // read selection from the shadow copies
    always_comb begin
        read_mux = READ_IDLE;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (addr_sel[i]) begin
                read_mux = shadow[i];
            end
        end
    end

    // composed fields, as they would stand after the next frame boundary
    logic nx_order;
    logic nx_subsample;
    logic nx_average;
    logic nx_partial;
    logic [WINDOW_W-1:0] nx_first_row;
    logic [WINDOW_W-1:0] nx_last_row;
    logic [WINDOW_W-1:0] nx_first_col;
    logic [WINDOW_W-1:0] nx_last_col;
    logic [FRAME_GAP_W-1:0] nx_frame_gap;
    logic [LINE_GAP_W-1:0] nx_line_gap;

    window_compose u_compose (
        .i_shadow(shadow),
        .o_column_order_select(nx_order),
        .o_column_subsample_enable(nx_subsample),
        .o_column_average_enable(nx_average),
        .o_partial_frame_enable(nx_partial),
        .o_window_first_row(nx_first_row),
        .o_window_last_row(nx_last_row),
        .o_window_first_col(nx_first_col),
        .o_window_last_col(nx_last_col),
        .o_frame_gap(nx_frame_gap),
        .o_line_gap(nx_line_gap)
    );

    // reset image of the active set, built from the reset bytes
    logic rs_order;
    logic rs_subsample;
    logic rs_average;
    logic rs_partial;
    logic [WINDOW_W-1:0] rs_first_row;
    logic [WINDOW_W-1:0] rs_last_row;
    logic [WINDOW_W-1:0] rs_first_col;
    logic [WINDOW_W-1:0] rs_last_col;
    logic [FRAME_GAP_W-1:0] rs_frame_gap;
    logic [LINE_GAP_W-1:0] rs_line_gap;

    window_compose u_reset_image (
        .i_shadow(REG_RESET),
        .o_column_order_select(rs_order),
        .o_column_subsample_enable(rs_subsample),
        .o_column_average_enable(rs_average),
        .o_partial_frame_enable(rs_partial),
        .o_window_first_row(rs_first_row),
        .o_window_last_row(rs_last_row),
        .o_window_first_col(rs_first_col),
        .o_window_last_col(rs_last_col),
        .o_frame_gap(rs_frame_gap),
        .o_line_gap(rs_line_gap)
    );

    // pending: a write sets, a frame boundary clears, set wins
    logic pending_r;
    logic pending_nxt;
    assign pending_nxt = any_write | (pending_r & ~i_frame_boundary);

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            pending_r <= 1'b0;
        end else begin
            pending_r <= pending_nxt;
        end
    end

    // read answer, one cycle after the request
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rdata <= READ_IDLE;
            o_rd_valid <= 1'b0;
            o_addr_hit <= 1'b0;
        end else begin
            o_rdata <= i_rd_en ? read_mux : READ_IDLE;
            o_rd_valid <= i_rd_en;
            o_addr_hit <= (i_rd_en | i_wr_en) & any_hit;
        end
    end

    // status outputs: pending copy and apply pulse
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_update_pending <= 1'b0;
            o_applied <= 1'b0;
        end else begin
            o_update_pending <= pending_nxt;
            o_applied <= i_frame_boundary;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_column_order_select <= rs_order;
            o_column_subsample_enable <= rs_subsample;
            o_column_average_enable <= rs_average;
            o_partial_frame_enable <= rs_partial;
        end else if (i_frame_boundary) begin
            o_column_order_select <= nx_order;
            o_column_subsample_enable <= nx_subsample;
            o_column_average_enable <= nx_average;
            o_partial_frame_enable <= nx_partial;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_window_first_row <= rs_first_row;
            o_window_last_row <= rs_last_row;
            o_window_first_col <= rs_first_col;
            o_window_last_col <= rs_last_col;
        end else if (i_frame_boundary) begin
            o_window_first_row <= nx_first_row;
            o_window_last_row <= nx_last_row;
            o_window_first_col <= nx_first_col;
            o_window_last_col <= nx_last_col;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_frame_gap <= rs_frame_gap;
            o_line_gap <= rs_line_gap;
        end else if (i_frame_boundary) begin
            o_frame_gap <= nx_frame_gap;
            o_line_gap <= nx_line_gap;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/readout_window_timing_regs_end.sv
`timescale 1ns/1ps

// >>> bench/rwt_monitor.sv
// checker for the register bank, watching only its ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module rwt_monitor
    import rwt_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_frame_boundary,
    input wire logic [7:0] o_rdata,
    input wire logic o_rd_valid,
    input wire logic o_addr_hit,
    input wire logic o_update_pending,
    input wire logic o_applied,
    input wire logic o_column_order_select,
    input wire logic o_column_subsample_enable,
    input wire logic o_column_average_enable,
    input wire logic o_partial_frame_enable,
    input wire logic [WINDOW_W-1:0] o_window_first_row,
    input wire logic [WINDOW_W-1:0] o_window_last_row,
    input wire logic [WINDOW_W-1:0] o_window_first_col,
    input wire logic [WINDOW_W-1:0] o_window_last_col,
    input wire logic [FRAME_GAP_W-1:0] o_frame_gap,
    input wire logic [LINE_GAP_W-1:0] o_line_gap
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    // window edges, delays and modes hold between boundaries
    property p_hold; !i_frame_boundary |=> $stable({o_window_first_row, o_window_last_row, o_window_first_col,
        o_window_last_col, o_frame_gap, o_line_gap, o_column_order_select, o_column_average_enable,
        o_column_subsample_enable, o_partial_frame_enable}); endproperty
    a_hold: assert property (p_hold) else $error("active value moved without boundary");
    property p_apply; i_frame_boundary && !i_wr_en |=> o_applied && !o_update_pending; endproperty
    a_apply: assert property (p_apply) else $error("boundary not applied");
    property p_pend; i_wr_en && i_addr == ADDR_W'(8'h13) |=> o_update_pending && o_addr_hit; endproperty
    a_pend: assert property (p_pend) else $error("write not pending");
    property p_avg_sub; o_column_average_enable |-> o_column_subsample_enable; endproperty
    a_avg_sub: assert property (p_avg_sub) else $error("averaging without subsampling");
    property p_frow; o_window_first_row[1:0] == 2'h0; endproperty
    a_frow: assert property (p_frow) else $error("first row low bits");
    property p_lrow; o_window_last_row[1:0] == 2'h3; endproperty
    a_lrow: assert property (p_lrow) else $error("last row low bits");
    property p_fcol; o_window_first_col[1:0] == 2'h0; endproperty
    a_fcol: assert property (p_fcol) else $error("first column low bits");
    property p_lcol; o_window_last_col[1:0] == 2'h3; endproperty
    a_lcol: assert property (p_lcol) else $error("last column low bits");
    property p_cfg_rd; i_rd_en && i_addr == ADDR_W'(8'h15) |=> o_rd_valid && (o_rdata & 8'hF7) == 8'h00; endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("reserved config bits read set");
    property p_unmap; i_rd_en && i_addr == ADDR_W'(8'h14) |=> o_rd_valid ##0 !o_addr_hit && o_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read answered");
    c_avg: cover property (i_frame_boundary ##1 o_column_average_enable);
    c_read: cover property (o_rd_valid && o_addr_hit);
    c_miss: cover property (o_rd_valid && !o_addr_hit);
endmodule
bind readout_window_timing_regs rwt_monitor #(.ADDR_W(ADDR_W)) u_mon (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_frame_boundary(i_frame_boundary),
    .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_addr_hit(o_addr_hit), .o_update_pending(o_update_pending),
    .o_applied(o_applied), .o_column_order_select(o_column_order_select),
    .o_column_subsample_enable(o_column_subsample_enable), .o_column_average_enable(o_column_average_enable),
    .o_partial_frame_enable(o_partial_frame_enable), .o_window_first_row(o_window_first_row),
    .o_window_last_row(o_window_last_row), .o_window_first_col(o_window_first_col),
    .o_window_last_col(o_window_last_col), .o_frame_gap(o_frame_gap), .o_line_gap(o_line_gap));
`default_nettype wire

// >>> bench/host_ctrl_model.sv
// host controller model: byte writes and reads on the control port
// assumes requests are launched at the falling edge of i_mclk
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_rdata,
    input wire logic i_addr_hit,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    // idle bus at time zero
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge i_mclk);
        o_wr_en = 1'b1;
        o_addr = a;
        o_wdata = (a == 8'h15) ? (v & 8'hF8) : v;
        @(negedge i_mclk);
        o_wr_en = 1'b0;
        o_addr = ~a; // released lines do not keep old value
        o_wdata = ~o_wdata;
    endtask
    // one byte read, answer taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge i_mclk);
        o_rd_en = 1'b1;
        o_addr = a;
        @(negedge i_mclk);
        // answer stands only in the cycle after the request edge
        d = i_rdata;
        h = i_addr_hit;
        o_rd_en = 1'b0;
        o_addr = ~a;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_readout_window_timing_regs.sv
// self-checking bench for the register bank
// assumes the host model drives the byte port, the bench drives boundaries
`timescale 1ns/1ps
`default_nettype none
module tb_readout_window_timing_regs;
    import rwt_pkg::*;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic fb = 1'b0;
    logic wr_en, rd_en, rd_valid, addr_hit, pending, applied, ord, sub, avg, partial, h;
    logic [7:0] addr, wdata, rdata, d;
    logic [10:0] frow, lrow, fcol, lcol;
    logic [14:0] fgap;
    logic [12:0] lgap;
    int fail_count = 0;
    int cmp_count = 0;
    // clock, 10 ns period
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    readout_window_timing_regs uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wdata(wdata), .i_frame_boundary(fb), .o_rdata(rdata), .o_rd_valid(rd_valid),
        .o_addr_hit(addr_hit), .o_update_pending(pending), .o_applied(applied), .o_column_order_select(ord),
        .o_column_subsample_enable(sub), .o_column_average_enable(avg), .o_partial_frame_enable(partial),
        .o_window_first_row(frow), .o_window_last_row(lrow), .o_window_first_col(fcol),
        .o_window_last_col(lcol), .o_frame_gap(fgap), .o_line_gap(lgap));
    host_ctrl_model host (.i_mclk(i_mclk), .i_rdata(rdata), .i_addr_hit(addr_hit), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    function automatic logic [10:0] edge_of(input logic [7:0] hi, input logic b2, input logic [1:0] lo);
        return {hi, b2, lo};
    endfunction
    // one-cycle frame boundary pulse
    task automatic pulse();
        @(negedge i_mclk);
        fb = 1'b1;
        @(negedge i_mclk);
        fb = 1'b0;
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d, h);
        check(d, exp);
    endtask
    // reset values on outputs and in every register
    task automatic t_reset_values();
        check(ord, 1'b1);
        check(sub, 1'b0);
        check(avg, 1'b0);
        check(partial, 1'b1);
        check(frow, edge_of(8'h00, 1'b1, 2'h0));
        check(lrow, edge_of(8'h80, 1'b0, 2'h3));
        check(fcol, edge_of(8'h00, 1'b1, 2'h0));
        check(lcol, edge_of(8'hA0, 1'b0, 2'h3));
        check(fgap, 15'h0008);
        check(lgap, 13'h0008);
        for (int i = 0; i < NUM_REGS; i++) begin
            rd_check(REG_OFFSET[i], REG_RESET[i]);
            check(h, 1'b1);
        end
    endtask
    // every scan mode, held until the boundary
    task automatic t_horizontal_scan_control();
        logic [2:0] v;
        logic [2:0] prev;
        prev = 3'h4;
        for (int i = 7; i >= 0; i--) begin
            v = 3'(i);
            host.wr(8'h13, {5'h1F, v});
            check({ord, avg}, {prev[2], prev[0]});
            check(pending, 1'b1);
            pulse();
            check({pending, applied}, 2'h1);
            check(ord, v[2]);
            check(sub, v[1] | v[0]);
            check(avg, v[0]);
            prev = v;
        end
    endtask
    // all window registers, low bits ignored
    task automatic t_window();
        host.wr(8'h19, 8'hA5);
        host.wr(8'h1A, 8'h5A);
        host.wr(8'h1B, 8'hFF);
        host.wr(8'h1C, 8'h3C);
        host.wr(8'h1D, 8'hC3);
        host.wr(8'h1E, 8'hDB);
        pulse();
        check(frow, edge_of(8'hA5, 1'b1, 2'h0));
        check(lrow, edge_of(8'h5A, 1'b1, 2'h3));
        check(fcol, edge_of(8'h3C, 1'b0, 2'h0));
        check(lcol, edge_of(8'hC3, 1'b0, 2'h3));
        rd_check(8'h1B, 8'h3F);
        rd_check(8'h1E, 8'h1B);
    endtask
    // frame and line gap composition
    task automatic t_gaps();
        host.wr(8'h20, 8'h81);
        host.wr(8'h21, 8'hC1);
        host.wr(8'h22, 8'h81);
        host.wr(8'h23, 8'hE1);
        pulse();
        check(fgap, {8'h81, 7'h41});
        check(lgap, {8'h81, 5'h01});
        rd_check(8'h23, 8'h01);
    endtask
    // partial frame integration off and on again
    task automatic t_partial();
        host.wr(8'h15, 8'h00);
        pulse();
        check(partial, 1'b0);
        rd_check(8'h15, 8'h00);
        host.wr(8'h15, 8'h0F);
        pulse();
        check(partial, 1'b1);
    endtask
    // unmapped address is neither stored nor answered
    task automatic t_unmapped();
        host.wr(8'h14, 8'hFF);
        rd_check(8'h14, 8'h00);
        check(h, 1'b0);
    endtask
    task automatic complete_run();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // main sequence after five reset cycles
    initial begin
        repeat (5) @(negedge i_mclk);
        i_resetn = 1'b1;
        t_reset_values();
        t_horizontal_scan_control();
        t_window();
        t_gaps();
        t_partial();
        t_unmapped();
        complete_run();
    end
    // watchdog against a hang
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
